/* File: src/jpeg_output_status_regs.vh */
// Register numbers, field positions and codes of the output status registers
`ifndef JPEG_OUTPUT_STATUS_REGS_VH
`define JPEG_OUTPUT_STATUS_REGS_VH

`define REG_ADDR_W              8
`define REG_OUTPUT_STATUS_WORD  8'h02
`define REG_ENCODED_LENGTH_LOW  8'h03
`define REG_FIFO_FULLNESS       8'h04

`define WM_CLEAR_BIT            4
`define WM_LSB                  4
`define WM_MSB                  5
`define QSET_LSB                6
`define QSET_MSB                7
`define LEN_HI_LSB              8
`define LEN_HI_MSB              15
`define LEN_LO_MSB              15
`define LEN_W                   24
`define LEN_HI_BIT              16

`define BAND_UNDER_QUARTER      2'h0
`define BAND_UNDER_HALF         2'h1
`define BAND_UNDER_3QUARTER     2'h2
`define BAND_3QUARTER_UP        2'h3

`define FULL_EMPTY              3'h0
`define FULL_UNDER_QUARTER      3'h1
`define FULL_UNDER_HALF         3'h3
`define FULL_UNDER_3QUARTER     3'h2
`define FULL_3QUARTER_UP        3'h6

`define QSET_ZERO               2'h0
`define QSET_ONE                2'h1
`define QSET_TWO                2'h2
`define QSET_RESERVED           2'h3

`define WM_RESET                2'h0
`define QSET_RESET              2'h0
`define LEN_RESET               24'h000000
`define LEN_MAX                 24'hffffff
`define FULLNESS_RESET          3'h0
`define RDATA_RESET             16'h0000

`endif

/* File: src/fill_band.v */
// Quarter band of FIFO occupancy
`timescale 1ns/1ps
`include "jpeg_output_status_regs.vh"
module fill_band #(
	parameter LW    = 11,
	parameter DEPTH = 1024
) (
	input  wire [LW-1:0] level,
	output reg  [1:0]    band,
	output wire          empty
);
	localparam [LW+3:0] Q1 = DEPTH;
	localparam [LW+3:0] Q2 = 2 * DEPTH;
	localparam [LW+3:0] Q3 = 3 * DEPTH;
	wire [LW+3:0] level4;

	assign level4 = {2'b00, level, 2'b00};
	assign empty  = (level == {LW{1'b0}});

	always @* begin
		if (level4 < Q1)
			band = `BAND_UNDER_QUARTER; // R2
		else if (level4 < Q2)
			band = `BAND_UNDER_HALF; // R2
		else if (level4 < Q3)
			band = `BAND_UNDER_3QUARTER; // R2
		else
			band = `BAND_3QUARTER_UP; // R1
	end
endmodule

/* File: src/jpeg_output_status_regs.v */
// Status registers of the compressed-image output path
//
// Summary of operation
// (R1) Writing a one to bit 4 of the first status register clears the watermark to the current band; its code 11 means at least three quarters full.
// (R2) Watermark codes 00, 01 and 10 mean under a quarter, a quarter to under half, and half to under three quarters full.
// (R3) Bits 7:6 report the quantization table set in use, 00, 01 or 10, with 11 reserved.
// (R4) Bits 15:8 of the first status register hold bits 23:16 of the length count.
// (R5) The low length register holds count bits 15:0, forming a 24-bit byte total with the high byte.
// (R6) On output FIFO overflow the length count stops and keeps the bytes already sent.
// (R7) A three-bit code shows instantaneous occupancy: 000, 001, 011, 010 and 110 by quarter bands.
// (R8) The watermark holds the highest band reached since its last clear, while the fullness code follows occupancy.
`timescale 1ns/1ps
`include "jpeg_output_status_regs.vh"
module jpeg_output_status_regs #(
	parameter LW    = 11,
	parameter DEPTH = 1024
) (
	input  wire                   clk,
	input  wire                   reset,
	input  wire [`REG_ADDR_W-1:0] reg_addr,
	input  wire                   reg_write,
	input  wire [15:0]            reg_wdata,
	input  wire                   reg_read,
	output reg  [15:0]            reg_rdata,
	output reg                    reg_rvalid,
	input  wire [LW-1:0]          fifo_level,
	input  wire                   byte_sent,
	input  wire                   fifo_overflow,
	input  wire                   frame_start,
	input  wire [1:0]             quant_table_set_select
);
	wire [1:0]        band;
	wire              empty;
	wire              wm_clear;
	reg  [1:0]        watermark;
	reg  [1:0]        next_watermark;
	reg  [1:0]        qset;
	reg  [`LEN_W-1:0] length_count;
	reg  [`LEN_W-1:0] next_length_count;
	reg               frozen;
	reg               next_frozen;
	reg  [2:0]        fullness;
	reg  [15:0]       next_rdata;

	function [2:0] fullness_code;
		input       is_empty;
		input [1:0] b;
		begin
			if (is_empty)
				fullness_code = `FULL_EMPTY;
			else begin
				case (b)
				`BAND_UNDER_QUARTER:  fullness_code = `FULL_UNDER_QUARTER;
				`BAND_UNDER_HALF:     fullness_code = `FULL_UNDER_HALF;
				`BAND_UNDER_3QUARTER: fullness_code = `FULL_UNDER_3QUARTER;
				default:              fullness_code = `FULL_3QUARTER_UP;
				endcase
			end
		end
	endfunction

	fill_band #(
		.LW    (LW),
		.DEPTH (DEPTH)
	) u_band (
		.level (fifo_level),
		.band  (band),
		.empty (empty)
	);

	assign wm_clear = reg_write &&
		(reg_addr == `REG_OUTPUT_STATUS_WORD) &&
		reg_wdata[`WM_CLEAR_BIT];

	always @* begin
		if (wm_clear)
			next_watermark = band; // R1
		else if (band > watermark)
			next_watermark = band; // R8
		else
			next_watermark = watermark;
	end

	always @* begin
		next_length_count = length_count;
		next_frozen       = frozen;
		if (frame_start) begin
			next_length_count = `LEN_RESET;
			next_frozen       = 1'b0;
		end else begin
			if (byte_sent && !frozen && length_count != `LEN_MAX)
				next_length_count = length_count + 1'b1; // R5
			if (fifo_overflow)
				next_frozen = 1'b1; // R6
		end
	end

	always @* begin
		next_rdata = `RDATA_RESET;
		case (reg_addr)
		`REG_OUTPUT_STATUS_WORD: begin
			next_rdata[`WM_MSB:`WM_LSB]         = watermark; // R1
			next_rdata[`QSET_MSB:`QSET_LSB]     = qset; // R3
			next_rdata[`LEN_HI_MSB:`LEN_HI_LSB] =
				length_count[`LEN_W-1:`LEN_HI_BIT]; // R4
		end
		`REG_ENCODED_LENGTH_LOW:
			next_rdata = length_count[`LEN_LO_MSB:0]; // R5
		`REG_FIFO_FULLNESS:
			next_rdata[2:0] = fullness; // R7
		default:
			next_rdata = `RDATA_RESET;
		endcase
	end

	always @(posedge clk) begin
		if (reset) begin
			watermark    <= `WM_RESET;
			qset         <= `QSET_RESET;
			length_count <= `LEN_RESET;
			frozen       <= 1'b0;
			fullness     <= `FULLNESS_RESET;
			reg_rdata    <= `RDATA_RESET;
			reg_rvalid   <= 1'b0;
		end else begin
			watermark    <= next_watermark;
			qset         <= quant_table_set_select; // R3
			length_count <= next_length_count;
			frozen       <= next_frozen;
			fullness     <= fullness_code(empty, band); // R7
			reg_rvalid   <= reg_read;
			if (reg_read)
				reg_rdata <= next_rdata;
		end
	end
endmodule

/* File: test/jpeg_status_chk_asserts.sv */
// Port assertions for the output status registers
`timescale 1ns/1ps
module jpeg_status_chk #(parameter LW = 11, DEPTH = 1024) (
	input wire clk, reset, reg_read, reg_rvalid, fifo_overflow, frame_start,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_rdata,
	input wire [LW-1:0] fifo_level,
	input wire [1:0] quant_table_set_select);
	reg up;
	wire rd2 = reg_read && reg_addr == 2;
	wire rd3 = reg_read && reg_addr == 3 && !frame_start;
	always @(posedge clk) up <= !reset;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_rv_pulse: assert property (reg_rvalid == $past(reg_read))
		else $error("rvalid");
	a_rd_hold: assert property (!reg_read |=> $stable(reg_rdata))
		else $error("hold");
	a_qset_field: assert property (rd2 && up |=> reg_rdata[7:6] ==
		$past(quant_table_set_select, 2)) else $error("qset");
	a_fill_empty: assert property (reg_read && reg_addr == 4 && up |=>
		(reg_rdata == 0) == ($past(fifo_level, 2) == 0)) else $error("fill");
	a_wm_floor: assert property (rd2 && up |=> reg_rdata[5:4] == 3 ||
		4 * $past(fifo_level, 2) < (reg_rdata[5:4] + 1) * DEPTH)
		else $error("wm");
	a_low_zero: assert property (rd2 |=> reg_rdata[3:0] == 0)
		else $error("low");
	a_len_frozen: assert property (fifo_overflow ##1 rd3 ##1 rd3 |=>
		$stable(reg_rdata)) else $error("len");
	a_unmapped: assert property (reg_read &&
		(reg_addr < 2 || reg_addr > 4) |=> reg_rdata == 0) else $error("map");
endmodule
bind jpeg_output_status_regs jpeg_status_chk #(.LW(LW), .DEPTH(DEPTH)) c (.*);

/* File: test/tb.sv */
// Self-checking bench for the output status registers
`timescale 1ns/1ps
module tb;
	reg clk = 0, reset = 1, reg_write = 0, reg_read = 0, byte_sent = 0;
	reg fifo_overflow = 0, frame_start = 0;
	reg [7:0] reg_addr = 0;
	reg [15:0] reg_wdata = 0;
	reg [10:0] fifo_level = 0;
	reg [1:0] quant_table_set_select = 0;
	reg [23:0] n = 0;
	wire [15:0] reg_rdata;
	wire reg_rvalid;
	integer seed = 91, num_errors = 0, n_tests = 0, i;
	always #10 clk = ~clk;
	jpeg_output_status_regs dut_u (.*);
	function [2:0] code(input [10:0] v);
		code = v == 0 ? 0 : v < 256 ? 1 : v < 512 ? 3 : v < 768 ? 2 : 6;
	endfunction
	task cmp(input [15:0] e, g);
		n_tests = n_tests + 1;
		num_errors = num_errors + (e !== g);
		if (e !== g) $display("wrong value reg%0h: %h, %h", reg_addr, e, g);
	endtask
	task acc(input w, input [7:0] a, input [15:0] v);
		@(negedge clk);
		{reg_write, reg_read, reg_addr, reg_wdata} = {w, !w, a, v};
		@(negedge clk);
		{reg_write, reg_read} = 0;
	endtask
	task test_done;
		$display("%0d errors, %0d checks", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		reset = 0;
		for (i = 0; i < 9; i = i + 1) begin
			fifo_level = i / 2 * 256 + i % 2 * 255;
			acc(0, 4, 0);
			cmp(code(fifo_level), reg_rdata);
		end
		for (i = 0; i < 4; i = i + 1) begin
			quant_table_set_select = i;
			acc(0, 2, 0);
			cmp(i, reg_rdata[7:6]);
		end
		cmp(3, reg_rdata[5:4]);
		fifo_level = 0;
		acc(1, 2, 16'h0010);
		fifo_level = 600;
		acc(0, 7, 0);
		cmp(0, reg_rdata);
		fifo_level = 0;
		acc(0, 2, 0);
		cmp(2, reg_rdata[5:4]);
		frame_start = 1;
		@(negedge clk);
		frame_start = 0;
		for (i = 0; i < 80000; i = i + 1) begin
			byte_sent = $random(seed) % 8 != 0;
			n = n + byte_sent;
			fifo_level = $unsigned($random(seed)) % 1025;
			quant_table_set_select = $random(seed);
			@(negedge clk);
		end
		{fifo_overflow, byte_sent} = 2'h3;
		n = n + 1;
		@(negedge clk);
		{fifo_overflow, reg_read, reg_addr} = {2'h1, 8'h03};
		repeat (2) @(negedge clk);
		{reg_read, byte_sent} = 0;
		acc(1, 3, 16'hffff);
		acc(0, 3, 0);
		cmp(n[15:0], reg_rdata);
		acc(0, 2, 0);
		cmp(n[23:16], reg_rdata[15:8]);
		test_done;
	end
endmodule
